// ### rtl/rsr_pkg.sv
// Constants and types for the reset source and retention block
package rsr_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_REMAP      = 32'hffff0220;
    localparam logic [31:0] ADDR_FLAGS      = 32'hffff0230;
    localparam logic [31:0] ADDR_CLEAR      = 32'hffff0234;
    localparam logic [31:0] ADDR_KEY_FIRST  = 32'hffff0248;
    localparam logic [31:0] ADDR_RETAIN     = 32'hffff024c;
    localparam logic [31:0] ADDR_KEY_SECOND = 32'hffff0250;

    // Reset source flag positions
    localparam int FLAG_POR  = 0;
    localparam int FLAG_WDT  = 1;
    localparam int FLAG_SOFT = 2;
    localparam int FLAG_W    = 3;

    // Remap field
    localparam int REMAP_BIT = 0;

    // Retention fields
    localparam int RET_GPIO = 0;
    localparam int RET_VDAC = 2;
    localparam int RET_IDAC = 3;
    localparam int RET_W    = 4;
    localparam logic [7:0] RET_MASK = 8'h0d;

    // Key codes
    localparam logic [7:0] KEY_FIRST_CODE  = 8'h76;
    localparam logic [7:0] KEY_SECOND_CODE = 8'hb1;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAGS_POR_VALUE = 3'h1;
    localparam logic [FLAG_W-1:0] FLAGS_NULL      = 3'h0;
    localparam logic [7:0]        RETAIN_RESET    = 8'h00;
    localparam logic [31:0]       DATA_ZERO       = 32'h00000000;

    // Key sequence states
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ARMED,
        KEY_LOADED
    } rsr_key_t;
endpackage : rsr_pkg

// ### rtl/rsr_top.sv
// Reset source bookkeeping, remap and retention block behind an APB slave
// Operation
// - Four reset causes told apart; causes accumulate in the flag register until cleared.
// - External pin reset leaves the flag register reading all zeros.
// - Writing one to flag bit 2 forces a software reset; bit stays set.
// - Watchdog timeout sets flag bit 1 by hardware.
// - Power-on reset sets flag bit 0 by hardware.
// - Writing one to a clear register bit clears the matching flag.
// - A clear leaving any set flag uncleared raises a reset event.
// - Remap bit 0 set puts SRAM at address zero instead of flash.
// - Any reset clears the remap bit so flash sits at address zero.
// - Retention update is key 0x76, then value, then key 0xb1.
// - Retention bit 3 keeps current DAC state across watchdog or software reset.
// - Retention bit 2 keeps voltage DAC state across watchdog or software reset.
// - Retention bit 0 keeps GPIO state across watchdog or software reset.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module rsr_top
    import rsr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        wdt_timeout,
    output logic             core_reset,
    output logic             gpio_reset,
    output logic             vdac_reset,
    output logic             idac_reset,
    output logic             remap_sram
);
    import rsr_pkg::*;

    logic [FLAG_W-1:0] flags;
    logic [7:0]        retain;
    logic [7:0]        retain_pending;
    rsr_key_t          key_state;
    logic              pin_s1;
    logic              pin_s2;
    logic              pin_s3;
    logic              pin_level;
    logic              wr_en;
    logic              rd_en;
    logic              hit;
    logic              ext_event;
    logic              soft_event;
    logic              partial_clear;
    logic              reset_event;
    logic [FLAG_W-1:0] clr_bits;
    logic [FLAG_W-1:0] next_flags;
    logic [31:0]       next_rdata;

    // APB handshake: every access gets one wait state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready & ~pwrite;
    assign hit   = (paddr == ADDR_REMAP) | (paddr == ADDR_FLAGS) | (paddr == ADDR_CLEAR) |
                   (paddr == ADDR_KEY_FIRST) | (paddr == ADDR_RETAIN) | (paddr == ADDR_KEY_SECOND);

    // Unmapped addresses answer with an error in the ready cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & penable & ~pready & ~hit;
        end
    end

    // Three-stage pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1    <= 1'b1;
            pin_s2    <= 1'b1;
            pin_s3    <= 1'b1;
            pin_level <= 1'b1;
        end else begin
            pin_s1 <= ext_reset_pin_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
        end
    end

    // Falling edge of the filtered pin level is the external reset
    assign ext_event  = pin_level & (pin_s2 == pin_s3) & ~pin_s3;
    assign soft_event = wr_en & (paddr == ADDR_FLAGS) & pwdata[FLAG_SOFT];
    assign clr_bits   = (wr_en & (paddr == ADDR_CLEAR)) ? pwdata[FLAG_W-1:0] : FLAGS_NULL;
    assign partial_clear = wr_en & (paddr == ADDR_CLEAR) & |(flags & ~pwdata[FLAG_W-1:0]);
    assign reset_event = ext_event | soft_event | wdt_timeout | partial_clear;

    // Flag update: hardware sets win over a clear in the same cycle
    always_comb begin
        next_flags = flags & ~clr_bits;
        if (wdt_timeout) begin
            next_flags[FLAG_WDT] = 1'b1;
        end
        if (soft_event) begin
            next_flags[FLAG_SOFT] = 1'b1;
        end
        if (ext_event) begin
            next_flags = FLAGS_NULL;
        end
    end

    // Only power-on loads the flag start value; external reset zeroes the flags, other resets keep them
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flags <= FLAGS_POR_VALUE;
        end else begin
            flags <= next_flags;
        end
    end

    // Reset request to the rest of the chip
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            core_reset <= 1'b0;
        end else begin
            core_reset <= reset_event;
        end
    end

    // Per-peripheral resets are masked by the retention bits, except on an external reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gpio_reset <= 1'b0;
            vdac_reset <= 1'b0;
            idac_reset <= 1'b0;
        end else begin
            gpio_reset <= reset_event & (ext_event | ~retain[RET_GPIO]);
            vdac_reset <= reset_event & (ext_event | ~retain[RET_VDAC]);
            idac_reset <= reset_event & (ext_event | ~retain[RET_IDAC]);
        end
    end

    // Remap bit; any reset returns flash to address zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            remap_sram <= 1'b0;
        end else if (reset_event) begin
            remap_sram <= 1'b0;
        end else if (wr_en && paddr == ADDR_REMAP) begin
            remap_sram <= pwdata[REMAP_BIT];
        end
    end

    // Key sequence: any other write in between breaks it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            key_state      <= KEY_IDLE;
            retain_pending <= RETAIN_RESET;
        end else if (wr_en) begin
            case (key_state)
                KEY_IDLE: begin
                    if (paddr == ADDR_KEY_FIRST && pwdata[7:0] == KEY_FIRST_CODE) begin
                        key_state <= KEY_ARMED;
                    end
                end
                KEY_ARMED: begin
                    if (paddr == ADDR_RETAIN) begin
                        key_state      <= KEY_LOADED;
                        retain_pending <= pwdata[7:0] & RET_MASK;
                    end else begin
                        key_state <= KEY_IDLE;
                    end
                end
                KEY_LOADED: begin
                    key_state <= KEY_IDLE;
                end
                default: begin
                    key_state <= KEY_IDLE;
                end
            endcase
        end
    end

    // Retention commits only on the closing key; power-on alone clears it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            retain <= RETAIN_RESET;
        end else if (wr_en && key_state == KEY_LOADED && paddr == ADDR_KEY_SECOND &&
                     pwdata[7:0] == KEY_SECOND_CODE) begin
            retain <= retain_pending;
        end
    end

    // Read mux; write-only keys and the clear register read as zero
    always_comb begin
        next_rdata = DATA_ZERO;
        if (paddr == ADDR_REMAP) begin
            next_rdata[REMAP_BIT] = remap_sram;
        end else if (paddr == ADDR_FLAGS) begin
            next_rdata[FLAG_W-1:0] = flags;
        end else if (paddr == ADDR_RETAIN) begin
            next_rdata[7:0] = retain;
        end
    end

    // Read data is registered and stands from the ready cycle on
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= DATA_ZERO;
        end else if (rd_en) begin
            prdata <= next_rdata;
        end
    end

    // Checks
    property p_wdt_flag;
        @(posedge clock) disable iff (!arst_n) wdt_timeout && !ext_event |=> flags[FLAG_WDT];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

    property p_soft_flag;
        @(posedge clock) disable iff (!arst_n) soft_event && !ext_event |=> flags[FLAG_SOFT] && core_reset;
    endproperty
    a_soft_flag: assert property (p_soft_flag) else $error("software reset not taken");

    property p_ext_null;
        @(posedge clock) disable iff (!arst_n) ext_event |=> flags == FLAGS_NULL && core_reset;
    endproperty
    a_ext_null: assert property (p_ext_null) else $error("external reset left flags set");

    property p_partial;
        @(posedge clock) disable iff (!arst_n) partial_clear |=> core_reset;
    endproperty
    a_partial: assert property (p_partial) else $error("partial clear gave no reset");

    property p_full_clear;
        @(posedge clock) disable iff (!arst_n)
            wr_en && paddr == ADDR_CLEAR && !reset_event |=> (flags & $past(pwdata[FLAG_W-1:0])) == FLAGS_NULL;
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("clear did not clear");

    property p_remap_reset;
        @(posedge clock) disable iff (!arst_n) reset_event |=> !remap_sram;
    endproperty
    a_remap_reset: assert property (p_remap_reset) else $error("remap survived reset");

    property p_remap_set;
        @(posedge clock) disable iff (!arst_n)
            wr_en && paddr == ADDR_REMAP && !reset_event |=> remap_sram == $past(pwdata[REMAP_BIT]);
    endproperty
    a_remap_set: assert property (p_remap_set) else $error("remap write lost");

    property p_retain_guard;
        @(posedge clock) disable iff (!arst_n) $changed(retain) |-> $past(key_state) == KEY_LOADED;
    endproperty
    a_retain_guard: assert property (p_retain_guard) else $error("retention changed without keys");

    property p_gpio_keep;
        @(posedge clock) disable iff (!arst_n) wdt_timeout && !ext_event && retain[RET_GPIO] |=> !gpio_reset;
    endproperty
    a_gpio_keep: assert property (p_gpio_keep) else $error("retained gpio was reset");

    property p_idac_drop;
        @(posedge clock) disable iff (!arst_n)
            soft_event && !ext_event && !retain[RET_IDAC] |=>
                idac_reset && vdac_reset == !$past(retain[RET_VDAC]);
    endproperty
    a_idac_drop: assert property (p_idac_drop) else $error("dac reset wrong");

    property p_retain_keep;
        @(posedge clock) disable iff (!arst_n)
            wdt_timeout && !(wr_en && paddr == ADDR_KEY_SECOND) |=> $stable(retain);
    endproperty
    a_retain_keep: assert property (p_retain_keep) else $error("retention lost on watchdog");

    property p_ready_one;
        @(posedge clock) disable iff (!arst_n) pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready held too long");

    c_key_commit: cover property (@(posedge clock) disable iff (!arst_n) $changed(retain));
    c_partial:    cover property (@(posedge clock) disable iff (!arst_n) partial_clear);
    c_ext:        cover property (@(posedge clock) disable iff (!arst_n) ext_event);
    c_remap:      cover property (@(posedge clock) disable iff (!arst_n) $rose(remap_sram));
endmodule // rsr_top

// ### testbench/rsr_top_test.sv
// Self-checking bench for the reset source and retention block
`timescale 1ns/1ps
module rsr_top_test;
    import rsr_pkg::*;
    logic        clock;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_reset_pin_n;
    logic        wdt_timeout;
    logic        core_reset;
    logic        gpio_reset;
    logic        vdac_reset;
    logic        idac_reset;
    logic        remap_sram;
    int          fails;
    int          checks_done;
    int          pulses [4] = '{default: 0};
    int          base [4];
    logic [33:0] notes [$];
    logic [33:0] note;
    logic [7:0]  val;

    rsr_top DUT (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout), .core_reset(core_reset),
        .gpio_reset(gpio_reset), .vdac_reset(vdac_reset), .idac_reset(idac_reset), .remap_sram(remap_sram));

    // Core clock, 4 ns period
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d, input logic [7:0] exp,
                       input logic err);
        notes.push_back({wr, err, 24'h000000, exp});
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        // No answer time assumed; only the hang guard ends a hung wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Answers take the oldest note at the ready edge; read data only compared on reads
    always @(posedge clock) begin
        if (pready === 1'b1) begin
            note = notes.pop_front();
            check("pslverr", 32'(pslverr), 32'(note[32]));
            if (!note[33]) begin
                check("prdata", prdata, note[31:0]);
            end
        end
    end

    // Reset pulse tally: core, gpio, voltage DAC, current DAC
    always @(posedge clock) begin
        pulses[0] <= pulses[0] + int'(core_reset);
        pulses[1] <= pulses[1] + int'(gpio_reset);
        pulses[2] <= pulses[2] + int'(vdac_reset);
        pulses[3] <= pulses[3] + int'(idac_reset);
    end

    // Compare pulses since the snapshot, only where care is set
    task automatic expect_pulses(input logic [3:0] exp, input logic [3:0] care);
        repeat (10) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            if (care[i]) check("reset pulses", 32'(pulses[i] - base[i]), 32'(exp[i]));
        end
    endtask

    // Full key sequence around the retention value
    task automatic keyed(input logic [7:0] v);
        apb(1'b1, ADDR_KEY_FIRST, KEY_FIRST_CODE, 8'h00, 1'b0);
        apb(1'b1, ADDR_RETAIN, v, 8'h00, 1'b0);
        apb(1'b1, ADDR_KEY_SECOND, KEY_SECOND_CODE, 8'h00, 1'b0);
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #40000;
        fails++;
        end_sim();
    end

    initial begin
        arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h00000000;
        pwdata = 32'h00000000; ext_reset_pin_n = 1'b1; wdt_timeout = 1'b0; fails = 0; checks_done = 0;
        void'($urandom(77231));
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        // Defaults after power-on, and an unmapped place
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h01, 1'b0);
        apb(1'b0, ADDR_REMAP, 8'h00, 8'h00, 1'b0);
        apb(1'b0, ADDR_RETAIN, 8'h00, RETAIN_RESET, 1'b0);
        apb(1'b0, 32'hffff0240, 8'h00, 8'h00, 1'b1);
        // Remap, then a software force clears it
        apb(1'b1, ADDR_REMAP, 8'h01, 8'h00, 1'b0);
        @(negedge clock);
        check("remap_sram", 32'(remap_sram), 32'h00000001);
        base = pulses;
        apb(1'b1, ADDR_FLAGS, 8'h04, 8'h00, 1'b0);
        expect_pulses(4'hf, 4'hf);
        check("remap_sram", 32'(remap_sram), 32'h00000000);
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h05, 1'b0);
        // Partial clear resets the core, full clear does not
        base = pulses;
        apb(1'b1, ADDR_CLEAR, 8'h04, 8'h00, 1'b0);
        expect_pulses(4'h1, 4'h1);
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h01, 1'b0);
        base = pulses;
        apb(1'b1, ADDR_CLEAR, 8'h01, 8'h00, 1'b0);
        expect_pulses(4'h0, 4'h1);
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h00, 1'b0);
        // Watchdog timeout pulse
        base = pulses;
        @(posedge clock);
        wdt_timeout <= 1'b1;
        @(posedge clock);
        wdt_timeout <= 1'b0;
        expect_pulses(4'h1, 4'h1);
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h02, 1'b0);
        // Retention writes outside a full key sequence are dropped
        apb(1'b1, ADDR_RETAIN, 8'h0d, 8'h00, 1'b0);
        apb(1'b1, ADDR_KEY_FIRST, KEY_FIRST_CODE, 8'h00, 1'b0);
        apb(1'b1, ADDR_REMAP, 8'h00, 8'h00, 1'b0);
        apb(1'b1, ADDR_RETAIN, 8'h0d, 8'h00, 1'b0);
        apb(1'b1, ADDR_KEY_SECOND, KEY_SECOND_CODE, 8'h00, 1'b0);
        apb(1'b0, ADDR_RETAIN, 8'h00, 8'h00, 1'b0);
        // All-set, all-clear and four random retention settings, each followed by a software force
        for (int i = 0; i < 6; i++) begin
            val = ((i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom)) & RET_MASK;
            keyed(val);
            apb(1'b0, ADDR_RETAIN, 8'h00, val & RET_MASK, 1'b0);
            base = pulses;
            apb(1'b1, ADDR_FLAGS, 8'h04, 8'h00, 1'b0);
            expect_pulses({~val[RET_IDAC], ~val[RET_VDAC], ~val[RET_GPIO], 1'b1}, 4'hf);
            apb(1'b0, ADDR_RETAIN, 8'h00, val & RET_MASK, 1'b0);
        end
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h06, 1'b0);
        // External pin: flags read null, every reset fires
        base = pulses;
        @(posedge clock);
        ext_reset_pin_n <= 1'b0;
        repeat (6) @(posedge clock);
        ext_reset_pin_n <= 1'b1;
        expect_pulses(4'hf, 4'hf);
        apb(1'b0, ADDR_FLAGS, 8'h00, 8'h00, 1'b0);
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule // rsr_top_test
